// file: setpoint_pkg.sv
// Package: command codes, field layout and reset values of the setpoint bank
package setpoint_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_VOUT_CEILING = 8'h24;
  localparam logic [7:0] CMD_MARGIN_UP = 8'h25;
  localparam logic [7:0] CMD_MARGIN_DOWN = 8'h26;
  localparam logic [7:0] CMD_SLEW_RATE = 8'h27;
  localparam logic [7:0] CMD_LOAD_LINE = 8'h28;
  localparam logic [7:0] CMD_LOOP_GAIN = 8'h29;
  localparam logic [7:0] CMD_MONITOR_SCALE = 8'h2A;
  localparam logic [7:0] CMD_DUTY_CEILING = 8'h32;
  localparam logic [7:0] CMD_SWITCH_KHZ = 8'h33;
  localparam logic [7:0] CMD_START_THRESH = 8'h35;
  localparam logic [7:0] CMD_STOP_THRESH = 8'h36;
  localparam logic [7:0] CMD_PHASE_GROUP = 8'h37;
  localparam logic [7:0] CMD_CURRENT_OFFSET = 8'h39;
  localparam logic [7:0] CMD_OV_THRESHOLD = 8'h40;

  // ==========================================================================
  // Storage slots of the writable words; the read-only offset has its own slot
  localparam int NUM_RW = 13;
  localparam logic [3:0] IDX_VOUT_CEILING = 4'h0;
  localparam logic [3:0] IDX_MARGIN_UP = 4'h1;
  localparam logic [3:0] IDX_MARGIN_DOWN = 4'h2;
  localparam logic [3:0] IDX_SLEW_RATE = 4'h3;
  localparam logic [3:0] IDX_LOAD_LINE = 4'h4;
  localparam logic [3:0] IDX_LOOP_GAIN = 4'h5;
  localparam logic [3:0] IDX_MONITOR_SCALE = 4'h6;
  localparam logic [3:0] IDX_DUTY_CEILING = 4'h7;
  localparam logic [3:0] IDX_SWITCH_KHZ = 4'h8;
  localparam logic [3:0] IDX_START_THRESH = 4'h9;
  localparam logic [3:0] IDX_STOP_THRESH = 4'hA;
  localparam logic [3:0] IDX_PHASE_GROUP = 4'hB;
  localparam logic [3:0] IDX_OV_THRESHOLD = 4'hC;
  localparam logic [3:0] IDX_CURRENT_OFFSET = 4'hD;

  // ==========================================================================
  // Field layout
  localparam int GROUP_ID_LSB = 8;
  localparam int RAIL_COUNT_LSB = 4;
  localparam int RAIL_POS_LSB = 0;
  localparam int NIBBLE_W = 4;
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_EXP_W = 5;
  localparam int LIN_MANT_W = 11;
  localparam int MODE_SEL_LSB = 5;
  localparam logic [2:0] MODE_SEL_LINEAR = 3'h0;

  // ==========================================================================
  // Reset values and the strap headroom (110 percent as 11 over 10)
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [19:0] CEIL_NUM = 20'h0000B;
  localparam logic [19:0] CEIL_DEN = 20'h0000A;

endpackage : setpoint_pkg

// file: phase_offset.sv
// Switching phase offset timer relative to the shared synchronisation clock
`timescale 1ns/1ns
`default_nettype none

module phase_offset #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Synchronisation and placement
  input wire logic sync_pulse,
  input wire logic [3:0] rail_count,
  input wire logic [3:0] rail_pos,
  // Delayed phase start
  output logic phase_start
);

  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] since_sync;
    logic [CNT_W-1:0] wait_left;
    logic armed;
    logic start;
  } po_state_t;

  po_state_t s_q;
  po_state_t s_d;
  logic [CNT_W+3:0] scaled;
  logic [CNT_W-1:0] delay;

  // ==========================================================================
  // Delay is period * position / count; a zero count means no spreading
  always_comb begin
    scaled = {4'h0, s_q.period} * {{CNT_W{1'b0}}, rail_pos};
    if (rail_count == 4'h0) begin
      delay = '0;
    end else begin
      delay = CNT_W'(scaled / {{CNT_W{1'b0}}, rail_count});
    end
  end

  // Period is measured between sync pulses, then the start waits its share
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.since_sync = s_q.since_sync + 1'b1;
    if (sync_pulse) begin
      s_d.period = s_q.since_sync + 1'b1;
      s_d.since_sync = '0;
      s_d.wait_left = delay;
      s_d.armed = 1'b1;
    end else if (s_q.armed) begin
      if (s_q.wait_left == '0) begin
        s_d.start = 1'b1;
        s_d.armed = 1'b0;
      end else begin
        s_d.wait_left = s_q.wait_left - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign phase_start = s_q.start;

endmodule : phase_offset

`default_nettype wire

// file: setpoint_bank.sv
// Output-voltage, switching and input-threshold setting bank behind a word command port
// Contract
// - Ceiling word clamped to 110% of strap
// - Hold margin-up target voltage word
// - Hold margin-down target voltage word
// - Hold transition rate word in volts/ms
// - Hold load-line droop slope word
// - Hold loop gain and monitor scale words
// - Hold duty-cycle ceiling percentage word
// - Hold switching frequency word in kHz
// - Start conversion when input reaches threshold
// - Stop conversion when input falls to threshold
// - Interleave bits 11:8 are group id
// - Interleave bits 7:4 are unit count
// - Offset switching phase by interleave position
// - Current offset word readable, never written
// - Compare output against over-voltage threshold
// - Mode bits 7:5 zero selects linear
`timescale 1ns/1ns
`default_nettype none

module setpoint_bank #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Command port, one byte per strobe
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic rd_req,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  output logic cmd_error,
  // Converter side inputs
  input wire logic [15:0] strap_vout,
  input wire logic [7:0] vout_mode,
  input wire logic [15:0] current_offset_src,
  input wire logic [15:0] vout_reading,
  input wire logic [15:0] vin_reading,
  input wire logic sync_pulse,
  // Settings to the converter
  output logic [15:0] vout_ceiling,
  output logic [15:0] margin_up,
  output logic [15:0] margin_down,
  output logic [15:0] slew_rate,
  output logic [15:0] load_line,
  output logic [15:0] loop_gain,
  output logic [15:0] monitor_scale,
  output logic [15:0] duty_ceiling,
  output logic [15:0] switch_khz,
  output logic [3:0] group_id,
  output logic [3:0] rail_count,
  output logic [3:0] rail_pos,
  // Derived status
  output logic vout_linear,
  output logic [4:0] vout_exponent,
  output logic conversion_on,
  output logic ov_fault,
  output logic phase_start
);

  typedef enum logic [0:0] {XF_IDLE, XF_OPEN} xfer_t;

  typedef struct packed {
    logic [setpoint_pkg::NUM_RW-1:0][15:0] regs;
    logic [3:0] slot;
    logic slot_ok;
    logic hi;
    logic [7:0] low_byte;
    logic [7:0] rd_byte;
    logic rd_valid;
    logic cmd_error;
    logic [15:0] strap;
    logic strap_ok;
    logic conv_on;
    logic ov_fault;
    xfer_t st;
  } bank_state_t;

  bank_state_t s_q;
  bank_state_t s_d;

  // ==========================================================================
  // Helpers

  // Command code to {known, slot}
  function automatic logic [4:0] decode_cmd(input logic [7:0] code);
    case (code)
      setpoint_pkg::CMD_VOUT_CEILING: decode_cmd = {1'b1, setpoint_pkg::IDX_VOUT_CEILING};
      setpoint_pkg::CMD_MARGIN_UP: decode_cmd = {1'b1, setpoint_pkg::IDX_MARGIN_UP};
      setpoint_pkg::CMD_MARGIN_DOWN: decode_cmd = {1'b1, setpoint_pkg::IDX_MARGIN_DOWN};
      setpoint_pkg::CMD_SLEW_RATE: decode_cmd = {1'b1, setpoint_pkg::IDX_SLEW_RATE};
      setpoint_pkg::CMD_LOAD_LINE: decode_cmd = {1'b1, setpoint_pkg::IDX_LOAD_LINE};
      setpoint_pkg::CMD_LOOP_GAIN: decode_cmd = {1'b1, setpoint_pkg::IDX_LOOP_GAIN};
      setpoint_pkg::CMD_MONITOR_SCALE: decode_cmd = {1'b1, setpoint_pkg::IDX_MONITOR_SCALE};
      setpoint_pkg::CMD_DUTY_CEILING: decode_cmd = {1'b1, setpoint_pkg::IDX_DUTY_CEILING};
      setpoint_pkg::CMD_SWITCH_KHZ: decode_cmd = {1'b1, setpoint_pkg::IDX_SWITCH_KHZ};
      setpoint_pkg::CMD_START_THRESH: decode_cmd = {1'b1, setpoint_pkg::IDX_START_THRESH};
      setpoint_pkg::CMD_STOP_THRESH: decode_cmd = {1'b1, setpoint_pkg::IDX_STOP_THRESH};
      setpoint_pkg::CMD_PHASE_GROUP: decode_cmd = {1'b1, setpoint_pkg::IDX_PHASE_GROUP};
      setpoint_pkg::CMD_OV_THRESHOLD: decode_cmd = {1'b1, setpoint_pkg::IDX_OV_THRESHOLD};
      setpoint_pkg::CMD_CURRENT_OFFSET: decode_cmd = {1'b1, setpoint_pkg::IDX_CURRENT_OFFSET};
      default: decode_cmd = 5'h00;
    endcase
  endfunction : decode_cmd

  // Linear word to a signed fixed-point value with 16 fraction bits
  function automatic logic signed [47:0] lin_value(input logic [15:0] w);
    logic signed [47:0] mant;
    logic [5:0] shift;
    mant = 48'(signed'(w[setpoint_pkg::LIN_MANT_W-1:0]));
    shift = 6'(signed'(w[15:setpoint_pkg::LIN_EXP_LSB])) + 6'h10;
    lin_value = mant <<< shift;
  endfunction : lin_value

  // Strap ceiling with headroom, saturated to the word
  function automatic logic [15:0] ceiling_limit(input logic [15:0] strap);
    logic [19:0] wide;
    wide = ({4'h0, strap} * setpoint_pkg::CEIL_NUM) / setpoint_pkg::CEIL_DEN;
    ceiling_limit = (wide[19:16] != 4'h0) ? 16'hFFFF : wide[15:0];
  endfunction : ceiling_limit

  // ==========================================================================
  // Next state
  always_comb begin
    logic [4:0] dec;
    logic [15:0] word;
    logic [15:0] rd_word;
    logic [15:0] limit;
    logic signed [47:0] vin_v;
    rd_word = 16'h0000;
    dec = decode_cmd(cmd_code);
    word = {wr_byte, s_q.low_byte};
    limit = ceiling_limit(s_q.strap);
    vin_v = lin_value(vin_reading);
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    s_d.cmd_error = 1'b0;

    // Strap is caught once, on the first edge after reset release
    if (!s_q.strap_ok) begin
      s_d.strap = strap_vout;
      s_d.strap_ok = 1'b1;
    end

    // Read source: stored word, live offset, or zero for unknown codes
    if (!s_q.slot_ok) begin
      rd_word = 16'h0000;
    end else if (s_q.slot == setpoint_pkg::IDX_CURRENT_OFFSET) begin
      rd_word = current_offset_src;
    end else begin
      rd_word = s_q.regs[s_q.slot];
    end

    case (s_q.st)
      XF_IDLE: begin
        if (wr_valid || rd_req) begin
          s_d.cmd_error = 1'b1; // Data with no command code
        end
      end
      XF_OPEN: begin
        if (rd_req) begin
          // Low byte first, then high
          s_d.rd_byte = s_q.hi ? rd_word[15:8] : rd_word[7:0];
          s_d.rd_valid = 1'b1;
          s_d.hi = ~s_q.hi;
          s_d.cmd_error = ~s_q.slot_ok;
        end else if (wr_valid) begin
          if (!s_q.slot_ok || s_q.slot == setpoint_pkg::IDX_CURRENT_OFFSET) begin
            s_d.cmd_error = 1'b1;
          end else if (!s_q.hi) begin
            s_d.low_byte = wr_byte;
            s_d.hi = 1'b1;
          end else begin
            // Whole word commits only on its high byte
            s_d.hi = 1'b0;
            if (s_q.slot == setpoint_pkg::IDX_VOUT_CEILING && word > limit) begin
              s_d.regs[s_q.slot] = limit;
            end else begin
              s_d.regs[s_q.slot] = word;
            end
          end
        end
      end
      default: s_d.st = XF_IDLE;
    endcase

    // A new command code restarts the byte pairing
    if (cmd_valid) begin
      s_d.st = XF_OPEN;
      s_d.slot = dec[3:0];
      s_d.slot_ok = dec[4];
      s_d.hi = 1'b0;
    end

    // Hysteresis: start at the on level, stop at the off level
    if (!s_q.conv_on) begin
      if (vin_v >= lin_value(s_q.regs[setpoint_pkg::IDX_START_THRESH])) begin
        s_d.conv_on = 1'b1;
      end
    end else if (vin_v <= lin_value(s_q.regs[setpoint_pkg::IDX_STOP_THRESH])) begin
      s_d.conv_on = 1'b0;
    end

    // Unsigned mode-format compare against the fault limit
    s_d.ov_fault = vout_reading > s_q.regs[setpoint_pkg::IDX_OV_THRESHOLD];
  end

  // ==========================================================================
  // State register; reset values are constants only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{regs: {setpoint_pkg::NUM_RW{setpoint_pkg::RST_WORD}}, st: XF_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Phase placement inside the interleave group
  phase_offset #(
    .CNT_W(CNT_W)
  ) u_phase (
    .mclk(mclk),
    .reset_n(reset_n),
    .sync_pulse(sync_pulse),
    .rail_count(rail_count),
    .rail_pos(rail_pos),
    .phase_start(phase_start)
  );

  // ==========================================================================
  // Outputs, all from flip-flops except vout_linear and vout_exponent, decoded from vout_mode directly
  assign rd_byte = s_q.rd_byte;
  assign rd_valid = s_q.rd_valid;
  assign cmd_error = s_q.cmd_error;
  assign vout_ceiling = s_q.regs[setpoint_pkg::IDX_VOUT_CEILING];
  assign margin_up = s_q.regs[setpoint_pkg::IDX_MARGIN_UP];
  assign margin_down = s_q.regs[setpoint_pkg::IDX_MARGIN_DOWN];
  assign slew_rate = s_q.regs[setpoint_pkg::IDX_SLEW_RATE];
  assign load_line = s_q.regs[setpoint_pkg::IDX_LOAD_LINE];
  assign loop_gain = s_q.regs[setpoint_pkg::IDX_LOOP_GAIN];
  assign monitor_scale = s_q.regs[setpoint_pkg::IDX_MONITOR_SCALE];
  assign duty_ceiling = s_q.regs[setpoint_pkg::IDX_DUTY_CEILING];
  assign switch_khz = s_q.regs[setpoint_pkg::IDX_SWITCH_KHZ];

  // Interleave fields; position zero for the sync source is the host's duty
  assign group_id = s_q.regs[setpoint_pkg::IDX_PHASE_GROUP][setpoint_pkg::GROUP_ID_LSB +:
    setpoint_pkg::NIBBLE_W];
  assign rail_count = s_q.regs[setpoint_pkg::IDX_PHASE_GROUP][setpoint_pkg::RAIL_COUNT_LSB +:
    setpoint_pkg::NIBBLE_W];
  assign rail_pos = s_q.regs[setpoint_pkg::IDX_PHASE_GROUP][setpoint_pkg::RAIL_POS_LSB +:
    setpoint_pkg::NIBBLE_W];

  // Mode byte interpretation
  assign vout_linear = vout_mode[7:setpoint_pkg::MODE_SEL_LSB] ==
    setpoint_pkg::MODE_SEL_LINEAR;
  assign vout_exponent = vout_mode[setpoint_pkg::LIN_EXP_W-1:0];
  assign conversion_on = s_q.conv_on;
  assign ov_fault = s_q.ov_fault;

endmodule : setpoint_bank

`default_nettype wire

// file: setpoint_chk.sv
// Checker: port-level relations of the setpoint bank
`timescale 1ns/1ns
`default_nettype none
module setpoint_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic wr_valid,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic cmd_error,
  // Settings and status
  input wire logic [15:0] strap_vout,
  input wire logic [7:0] vout_mode,
  input wire logic [15:0] vout_ceiling,
  input wire logic [15:0] margin_up,
  input wire logic [3:0] group_id,
  input wire logic [3:0] rail_count,
  input wire logic [3:0] rail_pos,
  input wire logic vout_linear,
  input wire logic [4:0] vout_exponent
);
  logic open_q;
  logic [7:0] cur_q;
  // ==========================================================
  // Open command; data in the same cycle still uses the old one
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      open_q <= 1'b0;
      cur_q <= 8'h00;
    end else if (cmd_valid) begin
      open_q <= 1'b1;
      cur_q <= cmd_code;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Relations
  a_read_answer: assert property (rd_req |=> rd_valid)
    else $error("read not answered");
  a_read_cause: assert property (rd_valid |-> $past(rd_req))
    else $error("read data without request");
  a_mode_linear: assert property (vout_linear == (vout_mode[7:5] == 3'h0))
    else $error("linear select wrong");
  a_mode_exp: assert property (vout_exponent == vout_mode[4:0])
    else $error("exponent wrong");
  a_orphan_data: assert property (wr_valid && !rd_req && !open_q |=> cmd_error)
    else $error("orphan byte not refused");
  a_offset_ro: assert property (wr_valid && !rd_req && open_q && cur_q == 8'h39 |=> cmd_error)
    else $error("offset write not refused");
  a_ceil_clamp: assert property ((32'(vout_ceiling) * 10) <= (32'(strap_vout) * 11))
    else $error("ceiling above headroom");
  a_margin_src: assert property ($changed(margin_up) |-> $past(wr_valid && cur_q == 8'h25))
    else $error("margin word changed unasked");
  a_group_src: assert property ($changed({group_id, rail_count, rail_pos}) |->
    $past(wr_valid && cur_q == 8'h37))
    else $error("interleave fields changed unasked");
endmodule : setpoint_chk
bind setpoint_bank setpoint_chk u_chk (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .wr_valid(wr_valid), .rd_req(rd_req), .rd_valid(rd_valid),
  .cmd_error(cmd_error), .strap_vout(strap_vout), .vout_mode(vout_mode),
  .vout_ceiling(vout_ceiling), .margin_up(margin_up), .group_id(group_id),
  .rail_count(rail_count), .rail_pos(rail_pos), .vout_linear(vout_linear),
  .vout_exponent(vout_exponent));
`default_nettype wire

// file: host_model.sv
// Host model driving the byte-wide word command port
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock
  input wire logic mclk,
  // Requests
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic rd_req,
  // Answers
  input wire logic [7:0] rd_byte,
  input wire logic rd_valid,
  input wire logic cmd_error
);
  int n_err = 0;
  int n_miss = 0;
  // ==========================================================
  // Idle at time zero, then count refusal pulses
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    wr_valid = 1'b0;
    wr_byte = 8'h00;
    rd_req = 1'b0;
  end
  always @(posedge mclk) begin
    if (cmd_error === 1'b1)
      n_err++;
  end
  // One strobe for one edge; data lines then flip so stale bytes never match
  task strobe(input int k, input logic [7:0] v);
    @(posedge mclk);
    if (k == 0) begin
      cmd_valid <= 1'b1;
      cmd_code <= v;
    end else if (k == 1) begin
      wr_valid <= 1'b1;
      wr_byte <= v;
    end else
      rd_req <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    wr_valid <= 1'b0;
    rd_req <= 1'b0;
    cmd_code <= ~cmd_code;
    wr_byte <= ~wr_byte;
  endtask : strobe
  // Word write, low byte first
  task wr_word(input logic [7:0] c, input logic [15:0] d);
    strobe(0, c);
    strobe(1, d[7:0]);
    strobe(1, d[15:8]);
  endtask : wr_word
  // Word read; answer looked at mid-cycle, while the one-cycle pulse stands
  task rd_word(input logic [7:0] c, output logic [15:0] d);
    int i;
    strobe(0, c);
    for (i = 0; i < 2; i++) begin
      strobe(2, 8'h00);
      @(negedge mclk);
      d[i*8 +: 8] = rd_byte;
      if (rd_valid !== 1'b1)
        n_miss++;
    end
  endtask : rd_word
endmodule : host_model
`default_nettype wire

// file: tb.sv
// Testbench for the setpoint bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk, reset_n, sync_pulse, cmd_valid, wr_valid, rd_req, rd_valid, cmd_error;
  logic conversion_on, ov_fault, phase_start, vout_linear;
  logic [3:0] group_id, rail_count, rail_pos;
  logic [4:0] vout_exponent;
  logic [7:0] cmd_code, wr_byte, rd_byte, vout_mode;
  logic [15:0] strap_vout, current_offset_src, vout_reading, vin_reading, vout_ceiling;
  logic [15:0] margin_up;
  logic [7:0] codes [13] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h32,
    8'h33, 8'h35, 8'h36, 8'h37, 8'h40};
  int n_errors = 0;
  int n_tests = 0;
  // ==========================================================
  // Instances
  host_model host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req), .rd_byte(rd_byte),
    .rd_valid(rd_valid), .cmd_error(cmd_error));
  setpoint_bank dut (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req),
    .rd_byte(rd_byte), .rd_valid(rd_valid), .cmd_error(cmd_error),
    .strap_vout(strap_vout), .vout_mode(vout_mode), .current_offset_src(current_offset_src),
    .vout_reading(vout_reading), .vin_reading(vin_reading), .sync_pulse(sync_pulse),
    .vout_ceiling(vout_ceiling), .margin_up(margin_up), .margin_down(), .slew_rate(),
    .load_line(), .loop_gain(), .monitor_scale(), .duty_ceiling(), .switch_khz(),
    .group_id(group_id), .rail_count(rail_count), .rail_pos(rail_pos),
    .vout_linear(vout_linear), .vout_exponent(vout_exponent),
    .conversion_on(conversion_on), .ov_fault(ov_fault), .phase_start(phase_start));
  // Compare and verdict
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task final_report();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Refusals: orphan byte, read-only offset, unknown code
  task t_refuse();
    int e;
    logic [15:0] d;
    e = host.n_err;
    host.strobe(1, 8'h55);
    repeat (2) @(posedge mclk);
    check(16'(host.n_err - e), 16'h0001);
    e = host.n_err;
    host.wr_word(8'h39, 16'hABCD);
    host.rd_word(8'h39, d);
    check(d, 16'h5A3C);
    check(16'(host.n_err > e), 16'h0001);
    e = host.n_err;
    host.rd_word(8'h30, d);
    repeat (2) @(posedge mclk);
    check(d, 16'h0000);
    check(16'(host.n_err > e), 16'h0001);
  endtask : t_refuse
  // Reset values, readback, ceiling headroom at strap 0x1000
  task t_regs();
    logic [7:0] c;
    logic [15:0] d;
    int i;
    for (i = 0; i < 13; i++) begin
      c = codes[i];
      host.rd_word(c, d);
      check(d, 16'h0000);
      host.wr_word(c, {c, c});
      host.rd_word(c, d);
      check(d, (c == 8'h24) ? 16'h1199 : {c, c});
    end
    check(margin_up, 16'h2525);
    host.wr_word(8'h24, 16'h119A);
    host.rd_word(8'h24, d);
    check(d, 16'h1199);
    host.wr_word(8'h24, 16'h1100);
    host.rd_word(8'h24, d);
    check(vout_ceiling, 16'h1100);
  endtask : t_regs
  // Mode selector and exponent
  task t_mode();
    int m;
    for (m = 0; m < 3; m++) begin
      @(posedge mclk);
      vout_mode <= {m[2:0], 5'h1B};
      @(posedge mclk);
      check(vout_linear, m == 0);
      check(vout_exponent, 16'h001B);
    end
  endtask : t_mode
  // Start at 48, stop at 40; 0x0818 is 24 times 2
  task t_conv();
    logic [15:0] vin [4] = '{16'h002D, 16'h0818, 16'h002D, 16'h0028};
    logic [3:0] ex = 4'b0110;
    int i;
    host.wr_word(8'h35, 16'h0030);
    host.wr_word(8'h36, 16'h0028);
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      vin_reading <= vin[i];
      repeat (3) @(posedge mclk);
      check(conversion_on, ex[i]);
    end
  endtask : t_conv
  // Over-voltage at and just above the threshold
  task t_ov();
    int i;
    host.wr_word(8'h40, 16'h1000);
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      vout_reading <= 16'h1000 + 16'(i);
      repeat (3) @(posedge mclk);
      check(ov_fault, 16'(i));
    end
  endtask : t_ov
  // Sync every 20 cycles; edge of the first phase pulse after the fourth sync
  task sync_run(output int d);
    int i;
    d = -1;
    for (i = 0; i < 80; i++) begin
      @(posedge mclk);
      sync_pulse <= (i % 20 == 0);
      if (phase_start === 1'b1 && i > 60 && d < 0)
        d = i;
    end
  endtask : sync_run
  task t_phase();
    int d0;
    int d1;
    host.wr_word(8'h37, 16'h0320);
    sync_run(d0);
    host.wr_word(8'h37, 16'h0321);
    sync_run(d1);
    check(16'(d1 - d0), 16'h000A);
    check({group_id, rail_count, rail_pos}, 16'h0321);
  endtask : t_phase
  // Clock, reset, sequence, watchdog
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    reset_n = 1'b0;
    sync_pulse = 1'b0;
    strap_vout = 16'h1000;
    vout_mode = 8'h00;
    current_offset_src = 16'h5A3C;
    vout_reading = 16'h0000;
    vin_reading = 16'h0000;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_refuse();
    t_regs();
    t_mode();
    t_conv();
    t_ov();
    t_phase();
    check(16'(host.n_miss), 16'h0000);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    final_report();
  end
endmodule : tb
`default_nettype wire
